// ==== hdl/psm_power_ctrl.v ====
// Operation
// - Higher-priority enabled interrupt wakes from Sleep.
// - Reset or watchdog time-out ends Sleep.
// - Low-priority interrupt in Sleep moves to Idle.
// - Idle halts CPU, system clock keeps running.
// - Stop-in-idle peripherals halt during Idle.
// - Wait with sleep-select clear enters Idle.
// - Only higher-priority interrupt wakes from Idle.
// - Reset or watchdog time-out ends Idle.
// - Start-up delay on waking disabled oscillator.
// - Two-bit divisor selects 1:1 to 1:8.
// - Core blocks stay on undivided system clock.
// - Peripheral read completes at next bus edge.
// - Deep-sleep enable selects Deep Sleep on wait with sleep-select set.
// - Deep-sleep enable hardware cleared, strap loaded.
// - Bit 13 retains general registers.
// - Bit 12 turns real-time clock off.
// - Bit 8 blocks real-time clock wake.
// - Bit 2 blocks external wake source.
// - Brown-out in Deep Sleep sets flag, no wake.
// - Bit 0 holds pins after Deep Sleep.
`timescale 1ns/1ps
`include "psm_map.vh"
module psm_power_ctrl #(
   parameter NPERIPH = 8,
   parameter PRIO_W = 3
) (
   input wire REF_CLK,
   input wire RST,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [3:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   input wire CPU_WAIT,
   input wire IRQ_PENDING,
   input wire [PRIO_W-1:0] IRQ_PRIO,
   input wire [PRIO_W-1:0] CPU_PRIO,
   input wire DEVICE_RESET,
   input wire WATCHDOG_TIMEOUT,
   input wire RTC_WAKE,
   input wire EXT_WAKE,
   input wire BROWNOUT_EVENT,
   input wire DS_ENABLE_STRAP,
   input wire OSC_NEEDS_STARTUP,
   input wire PERIPH_RD_REQ,
   output reg PERIPH_RD_DONE,
   output reg CPU_HALT,
   output reg SYS_CLK_EN,
   output reg CORE_CLK_EN,
   output reg PB_CLK_EN,
   output reg [NPERIPH-1:0] PERIPH_HALT,
   output reg GP_RETAIN,
   output reg RTC_OFF,
   output reg PIN_HOLD,
   output reg [3:0] MODE
);
   localparam ST_RUN = 5'h01;
   localparam ST_IDLE = 5'h02;
   localparam ST_SLEEP = 5'h04;
   localparam ST_DEEP = 5'h08;
   localparam ST_START = 5'h10;
   localparam integer STARTUP_CYC = (`PSM_STARTUP_NS + `PSM_CLK_NS - 1) / `PSM_CLK_NS;

   reg [4:0] state_reg, state_next;
   reg [31:0] osc_reg;
   reg [31:0] ds_reg;
   reg [NPERIPH-1:0] stop_idle_reg;
   reg strap_done_reg;
   reg [7:0] start_cnt_reg;
   reg rd_pend_reg;
   wire pb_edge;
   wire irq_wake;
   wire irq_low;
   wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire hard_wake = DEVICE_RESET || WATCHDOG_TIMEOUT;

   // Byte-lane merge for register writes.
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] sel;
      integer i;
      begin
         lane_merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (sel[i])
               lane_merge[i*8 +: 8] = din[i*8 +: 8];
      end
   endfunction

   // Stop-in-idle write data, merged at full bus width and cut to the peripheral count below.
   wire [31:0] stop_idle_merged;
   assign stop_idle_merged = lane_merge({{(32-NPERIPH){1'b0}}, stop_idle_reg}, WB_DAT_I,
      WB_SEL_I);

   psm_wake_logic #(.PRIO_W(PRIO_W)) u_wake (
      .clk(REF_CLK),
      .rst(RST),
      .irq_pending(IRQ_PENDING),
      .irq_prio(IRQ_PRIO),
      .cpu_prio(CPU_PRIO),
      .wake_reg(irq_wake),
      .low_irq_reg(irq_low)
   );

   // The bus clock runs in Run and Idle only; Sleep stops it.
   psm_pb_divider u_div (
      .clk(REF_CLK),
      .rst(RST),
      .run(state_next == ST_RUN || state_next == ST_IDLE),
      .div_sel(osc_reg[`PSM_PB_DIV_HI:`PSM_PB_DIV_LO]),
      .pb_edge_reg(pb_edge)
   );

   // Mode sequencing between run and the three low-power states.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (CPU_WAIT) begin
               if (!osc_reg[`PSM_SLEEP_SELECT_BIT])
                  state_next = ST_IDLE;
               else if (ds_reg[`PSM_DS_ENABLE_BIT])
                  state_next = ST_DEEP;
               else
                  state_next = ST_SLEEP;
            end
         end
         ST_IDLE: begin
            if (irq_wake || hard_wake)
               state_next = ST_RUN;
         end
         ST_SLEEP: begin
            if (irq_wake || hard_wake)
               state_next = OSC_NEEDS_STARTUP ? ST_START : ST_RUN;
            else if (irq_low)
               state_next = ST_IDLE;
         end
         ST_DEEP: begin
            // A brown-out is only recorded, never a wake source.
            if (hard_wake || (RTC_WAKE && !ds_reg[`PSM_RTC_WAKE_BLOCK_BIT]) ||
                (EXT_WAKE && !ds_reg[`PSM_EXT_WAKE_BLOCK_BIT]))
               state_next = OSC_NEEDS_STARTUP ? ST_START : ST_RUN;
         end
         ST_START: begin
            if (start_cnt_reg == 8'h00)
               state_next = ST_RUN;
         end
         default: state_next = ST_RUN;
      endcase
   end

   // State, start-up timer and strap capture.
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_RUN;
         start_cnt_reg <= 8'h00;
         strap_done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         strap_done_reg <= 1'b1;
         if (state_next == ST_START && state_reg != ST_START)
            start_cnt_reg <= STARTUP_CYC[7:0] - 8'h1;
         else if (start_cnt_reg != 8'h00)
            start_cnt_reg <= start_cnt_reg - 8'h1;
      end
   end

   // Register file; deep-sleep enable is taken from the strap after reset release.
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         osc_reg <= `PSM_OSC_RESET;
         ds_reg <= `PSM_DS_RESET;
         stop_idle_reg <= {NPERIPH{1'b0}};
      end else begin
         if (wb_req && WB_WE_I) begin
            case (WB_ADR_I)
               `PSM_OSC_CTRL_ADDR: osc_reg <= lane_merge(osc_reg, WB_DAT_I, WB_SEL_I) &
                  `PSM_OSC_WMASK;
               `PSM_DS_CTRL_ADDR: ds_reg <= lane_merge(ds_reg, WB_DAT_I, WB_SEL_I) &
                  `PSM_DS_WMASK;
               `PSM_STOP_IDLE_ADDR: stop_idle_reg <= stop_idle_merged[NPERIPH-1:0];
               default: ;
            endcase
         end
         if (!strap_done_reg)
            ds_reg[`PSM_DS_ENABLE_BIT] <= DS_ENABLE_STRAP;
         else if (state_reg == ST_DEEP && state_next != ST_DEEP)
            ds_reg[`PSM_DS_ENABLE_BIT] <= 1'b0;
         if (state_reg == ST_DEEP && BROWNOUT_EVENT)
            ds_reg[`PSM_DS_BROWNOUT_BIT] <= 1'b1;
      end
   end

   // Wishbone answer one cycle after the strobe; unmapped reads give zero.
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= wb_req;
         case (WB_ADR_I)
            `PSM_OSC_CTRL_ADDR: WB_DAT_O <= osc_reg;
            `PSM_DS_CTRL_ADDR: WB_DAT_O <= ds_reg;
            `PSM_STOP_IDLE_ADDR: WB_DAT_O <= {{(32-NPERIPH){1'b0}}, stop_idle_reg};
            `PSM_STATUS_ADDR: WB_DAT_O <= {27'h0000000, state_reg};
            default: WB_DAT_O <= 32'h00000000;
         endcase
      end
   end

   // Peripheral reads wait for the next divided bus edge.
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rd_pend_reg <= 1'b0;
         PERIPH_RD_DONE <= 1'b0;
      end else begin
         PERIPH_RD_DONE <= 1'b0;
         if (PERIPH_RD_REQ || rd_pend_reg) begin
            if (pb_edge) begin
               PERIPH_RD_DONE <= 1'b1;
               rd_pend_reg <= 1'b0;
            end else
               rd_pend_reg <= 1'b1;
         end
      end
   end

   // Clock gates and mode outputs, all registered.
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         CPU_HALT <= 1'b0;
         SYS_CLK_EN <= 1'b1;
         CORE_CLK_EN <= 1'b1;
         PB_CLK_EN <= 1'b0;
         PERIPH_HALT <= {NPERIPH{1'b0}};
         GP_RETAIN <= 1'b0;
         RTC_OFF <= 1'b0;
         PIN_HOLD <= 1'b0;
         MODE <= 4'h0;
      end else begin
         CPU_HALT <= state_next != ST_RUN;
         SYS_CLK_EN <= state_next == ST_RUN || state_next == ST_IDLE;
         CORE_CLK_EN <= state_next == ST_RUN || state_next == ST_IDLE;
         PB_CLK_EN <= pb_edge;
         PERIPH_HALT <= (state_next == ST_IDLE) ? stop_idle_reg : {NPERIPH{1'b0}};
         GP_RETAIN <= ds_reg[`PSM_GP_RETAIN_BIT];
         RTC_OFF <= ds_reg[`PSM_RTC_OFF_BIT];
         PIN_HOLD <= ds_reg[`PSM_PIN_HOLD_BIT];
         MODE <= state_next[3:0];
      end
   end
endmodule // psm_power_ctrl

// ==== hdl/psm_map.vh ====
`ifndef PSM_MAP_VH
`define PSM_MAP_VH
// Register byte offsets on the Wishbone slave.
`define PSM_OSC_CTRL_ADDR 4'h0
`define PSM_DS_CTRL_ADDR 4'h4
`define PSM_STOP_IDLE_ADDR 4'h8
`define PSM_STATUS_ADDR 4'hc
// Oscillator control field positions.
`define PSM_SLEEP_SELECT_BIT 4
`define PSM_PB_DIV_LO 19
`define PSM_PB_DIV_HI 20
// Deep sleep control field positions.
`define PSM_DS_ENABLE_BIT 15
`define PSM_GP_RETAIN_BIT 13
`define PSM_RTC_OFF_BIT 12
`define PSM_RTC_WAKE_BLOCK_BIT 8
`define PSM_EXT_WAKE_BLOCK_BIT 2
`define PSM_DS_BROWNOUT_BIT 1
`define PSM_PIN_HOLD_BIT 0
// Divisor encodings and reset values.
`define PSM_DIV_1 2'h0
`define PSM_DIV_2 2'h1
`define PSM_DIV_4 2'h2
`define PSM_DIV_8 2'h3
`define PSM_OSC_RESET 32'h00000000
`define PSM_DS_RESET 32'h00000000
`define PSM_OSC_WMASK 32'h00180010
`define PSM_DS_WMASK 32'h0000b105
// Clock start-up delay in ns, at a 50 ns system clock.
`define PSM_STARTUP_NS 1000
`define PSM_CLK_NS 50
`endif

// ==== hdl/psm_pb_divider.v ====
`timescale 1ns/1ps
`include "psm_map.vh"
module psm_pb_divider (
   input wire clk,
   input wire rst,
   input wire run,
   input wire [1:0] div_sel,
   output reg pb_edge_reg
);
   reg [2:0] cnt_reg;
   reg [1:0] div_reg;
   reg [2:0] last;

   // Terminal count of the active divisor.
   always @* begin
      case (div_reg)
         `PSM_DIV_1: last = 3'h0;
         `PSM_DIV_2: last = 3'h1;
         `PSM_DIV_4: last = 3'h3;
         default: last = 3'h7;
      endcase
   end

   // A new divisor is taken only at the period boundary so no pulse is shortened.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 3'h0;
         div_reg <= `PSM_DIV_1;
         pb_edge_reg <= 1'b0;
      end else if (!run) begin
         cnt_reg <= 3'h0;
         pb_edge_reg <= 1'b0;
      end else if (cnt_reg == last) begin
         cnt_reg <= 3'h0;
         div_reg <= div_sel;
         pb_edge_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
         pb_edge_reg <= 1'b0;
      end
   end
endmodule // psm_pb_divider

// ==== hdl/psm_wake_logic.v ====
`timescale 1ns/1ps
module psm_wake_logic #(
   parameter PRIO_W = 3
) (
   input wire clk,
   input wire rst,
   input wire irq_pending,
   input wire [PRIO_W-1:0] irq_prio,
   input wire [PRIO_W-1:0] cpu_prio,
   output reg wake_reg,
   output reg low_irq_reg
);
   // Registered compare keeps the wake decision off the priority path.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_reg <= 1'b0;
         low_irq_reg <= 1'b0;
      end else begin
         wake_reg <= irq_pending && (irq_prio > cpu_prio);
         low_irq_reg <= irq_pending && (irq_prio <= cpu_prio);
      end
   end
endmodule // psm_wake_logic

// ==== sim/psm_power_ctrl_assertions.sv ====
`timescale 1ns/1ps
module psm_power_ctrl_chk #(
   parameter PRIO_W = 3
) (
   input wire REF_CLK,
   input wire RST,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_ACK_O,
   input wire CPU_HALT,
   input wire SYS_CLK_EN,
   input wire CORE_CLK_EN,
   input wire [3:0] MODE,
   input wire IRQ_PENDING,
   input wire [PRIO_W-1:0] IRQ_PRIO,
   input wire [PRIO_W-1:0] CPU_PRIO,
   input wire DEVICE_RESET,
   input wire WATCHDOG_TIMEOUT,
   input wire PERIPH_RD_REQ,
   input wire PERIPH_RD_DONE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // A request that outranks the CPU is the only interrupt that may end a halt.
   wire hi = IRQ_PENDING && (IRQ_PRIO > CPU_PRIO);
   wire calm = !hi && !DEVICE_RESET && !WATCHDOG_TIMEOUT;
   property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("bus request not acknowledged");
   property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");
   property p_idle_halt; MODE[1] |-> CPU_HALT && SYS_CLK_EN; endproperty
   a_idle_halt: assert property (p_idle_halt) else $error("idle without halt");
   property p_core; MODE[0] || MODE[1] |-> CORE_CLK_EN; endproperty
   a_core: assert property (p_core) else $error("core clock stopped");
   property p_idle_stay; (MODE[1] && calm) [*3] |=> MODE[1]; endproperty
   a_idle_stay: assert property (p_idle_stay) else $error("idle left without cause");
   property p_idle_wake; MODE[1] && hi |-> ##[1:3] MODE[0]; endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle not woken");
   property p_sleep_wake; MODE[2] && hi |-> ##[1:30] MODE[0]; endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not woken");
   property p_sleep_wdt; MODE[2] && WATCHDOG_TIMEOUT |-> ##[1:30] !MODE[2]; endproperty
   a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep kept on time-out");
   property p_rd; MODE[0] && PERIPH_RD_REQ |-> ##[1:9] PERIPH_RD_DONE; endproperty
   a_rd: assert property (p_rd) else $error("peripheral read late");
   c_idle: cover property (MODE[1]);
   c_deep: cover property (MODE[3]);
   c_sleep_hi: cover property (MODE[2] && hi);
endmodule // psm_power_ctrl_chk
bind psm_power_ctrl psm_power_ctrl_chk #(.PRIO_W(PRIO_W)) u_chk (.*);

// ==== sim/psm_cpu_model.sv ====
`timescale 1ns/1ps
module psm_cpu_model (
   input wire clk,
   input wire wait_cmd,
   input wire rd_cmd,
   input wire rd_done,
   output reg cpu_wait = 1'b0,
   output reg rd_req = 1'b0,
   output reg [3:0] lat = 4'h0
);
   reg busy = 1'b0;
   // The core stalls on a peripheral read; lat counts the stall in clocks.
   always @(posedge clk) begin
      cpu_wait <= wait_cmd;
      rd_req <= rd_cmd;
      if (rd_req) begin
         busy <= 1'b1;
         lat <= 4'h0;
      end else if (busy) begin
         lat <= lat + 4'h1;
         busy <= !rd_done;
      end
   end
endmodule // psm_cpu_model

// ==== sim/psm_power_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`include "psm_map.vh"
module psm_power_ctrl_tb_top;
   reg clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, wt = 1'b0, rd = 1'b0;
   reg irq = 1'b0, wdt = 1'b0, dr = 1'b0, rtcw = 1'b0, extw = 1'b0, bor = 1'b0, osu = 1'b0;
   reg strap = 1'b1;
   reg [3:0] adr = 4'h0, sel = 4'h0;
   reg [31:0] wd = 32'h0, q;
   reg [2:0] ip = 3'h0;
   wire ack, cw, rq, dn, halt, sclk, cclk, pben, gp, rtco, pinh;
   wire [31:0] rdat;
   wire [7:0] ph;
   wire [3:0] md, lat;
   integer miscompares = 0, cmp_count = 0, i, n;
   psm_cpu_model CPU (.clk(clk), .wait_cmd(wt), .rd_cmd(rd), .rd_done(dn), .cpu_wait(cw),
      .rd_req(rq), .lat(lat));
   psm_power_ctrl DUT (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .CPU_WAIT(cw), .IRQ_PENDING(irq), .IRQ_PRIO(ip), .CPU_PRIO(3'h3), .DEVICE_RESET(dr),
      .WATCHDOG_TIMEOUT(wdt), .RTC_WAKE(rtcw), .EXT_WAKE(extw), .BROWNOUT_EVENT(bor),
      .DS_ENABLE_STRAP(strap), .OSC_NEEDS_STARTUP(osu), .PERIPH_RD_REQ(rq),
      .PERIPH_RD_DONE(dn), .CPU_HALT(halt), .SYS_CLK_EN(sclk), .CORE_CLK_EN(cclk),
      .PB_CLK_EN(pben), .PERIPH_HALT(ph), .GP_RETAIN(gp), .RTC_OFF(rtco), .PIN_HOLD(pinh),
      .MODE(md));
   initial forever #25 clk = ~clk;
   task summarize; begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   end endtask
   task chk(input [31:0] g, input [31:0] e); begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   end endtask
   // Classic cycle: hold everything until ack is seen on a rising edge.
   task wb(input w, input [3:0] a, input [31:0] d); begin
      @(posedge clk);
      {cyc, stb, we, adr, wd, sel} <= {2'h3, w, a, d, 4'hf};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'h0;
   end endtask
   // Waits for a mode with a count, so a wake that never comes is reported.
   task mode(input [3:0] m); begin
      n = 0;
      while (md !== m && n < 60) begin
         @(posedge clk);
         n = n + 1;
      end
      chk(md, m);
   end endtask
   task halt_cpu(input [31:0] osc, input [3:0] m); begin
      wb(1'b1, `PSM_OSC_CTRL_ADDR, osc);
      @(posedge clk) wt <= 1'b1;
      @(posedge clk) wt <= 1'b0;
      mode(m);
   end endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares = miscompares + 1;
      summarize;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      wb(1'b0, `PSM_DS_CTRL_ADDR, 32'h0);
      chk(q, 32'h00008000);
      wb(1'b1, `PSM_DS_CTRL_ADDR, 32'hffffffff);
      wb(1'b0, `PSM_DS_CTRL_ADDR, 32'h0);
      chk(q, `PSM_DS_WMASK);
      chk({gp, rtco, pinh}, 3'h7);
      wb(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0);
      // Clear the deep sleep options again, or the first wait with sleep-select set would enter Deep Sleep.
      wb(1'b1, `PSM_DS_CTRL_ADDR, 32'h0);
      @(posedge clk);
      chk({gp, rtco, pinh}, 3'h0);
      $display("Test registers done");
      for (i = 0; i < 4; i = i + 1) begin
         wb(1'b1, `PSM_OSC_CTRL_ADDR, {11'h0, i[1:0], 19'h0});
         repeat (16) @(posedge clk);
         n = 0;
         repeat (64) @(posedge clk) n = n + pben;
         chk(n, 64 >> i);
         chk(cclk, 1'b1);
         @(posedge clk) rd <= 1'b1;
         @(posedge clk) rd <= 1'b0;
         repeat (12) @(posedge clk);
         chk(lat >= 1 && lat <= (1 << i) + 1, 1);
      end
      $display("Test divisor done");
      wb(1'b1, `PSM_STOP_IDLE_ADDR, 32'h0f);
      halt_cpu(32'h0, 4'h2);
      chk({ph, halt, sclk, cclk}, {8'h0f, 3'h7});
      // Priority equal to the CPU's must not wake from Idle.
      {irq, ip} <= 4'hb;
      repeat (10) @(posedge clk);
      chk(md, 4'h2);
      ip <= 3'h5;
      mode(4'h1);
      irq <= 1'b0;
      chk(ph, 8'h00);
      halt_cpu(32'h0, 4'h2);
      wdt <= 1'b1;
      mode(4'h1);
      wdt <= 1'b0;
      $display("Test idle done");
      halt_cpu(32'h10, 4'h4);
      {irq, ip} <= 4'ha;
      mode(4'h2);
      ip <= 3'h5;
      mode(4'h1);
      irq <= 1'b0;
      halt_cpu(32'h10, 4'h4);
      irq <= 1'b1;
      mode(4'h1);
      irq <= 1'b0;
      halt_cpu(32'h10, 4'h4);
      wdt <= 1'b1;
      mode(4'h1);
      wdt <= 1'b0;
      $display("Test sleep done");
      wb(1'b1, `PSM_DS_CTRL_ADDR, 32'h00008100);
      osu <= 1'b1;
      halt_cpu(32'h10, 4'h8);
      rtcw <= 1'b1;
      bor <= 1'b1;
      repeat (30) @(posedge clk);
      chk(md, 4'h8);
      {rtcw, bor, extw} <= 3'h1;
      mode(4'h1);
      chk(n > 19, 1);
      extw <= 1'b0;
      wb(1'b0, `PSM_DS_CTRL_ADDR, 32'h0);
      chk(q, 32'h00000102);
      halt_cpu(32'h10, 4'h4);
      dr <= 1'b1;
      mode(4'h1);
      dr <= 1'b0;
      $display("Test deep sleep done");
      // A second reset with the strap low must leave deep-sleep enable clear.
      strap <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk(md, 4'h1);
      wb(1'b0, `PSM_DS_CTRL_ADDR, 32'h0);
      chk(q, 32'h0);
      $display("Test strap done");
      summarize;
   end
endmodule // psm_power_ctrl_tb_top
